// ### hdl/qire_pkg.sv
// package of constants for the four-line io read engine
package qire_pkg;
	localparam logic [7:0] OPC_READ       = 8'hEB; // four-line io read
	localparam logic [7:0] OPC_READ_WIDE  = 8'hEC; // four-line io read, wide address
	localparam logic [3:0] MODE_CONTINUE  = 4'hA;  // upper nibble keeping continuous mode
	localparam int         OPC_BITS       = 8;
	localparam int         MODE_CYCLES    = 2;
	localparam int         EXIT_MAX_CLKS  = 8;     // short frame length that forces exit
	localparam int         CFG_QUAD_BIT   = 1;     // four-line enable bit position
	localparam int         LAT_W          = 2;     // latency code width
	localparam int         BUF_DEPTH      = 2;
	typedef enum {
		QIRE_IDLE,
		QIRE_OPCODE,
		QIRE_ADDR,
		QIRE_MODE,
		QIRE_DUMMY,
		QIRE_DATA,
		QIRE_IGNORE
	} qire_state_e;
endpackage : qire_pkg

// ### hdl/qire_engine.sv
// four-line io read engine: serial command decode, address, mode, latency and nibble output
// Overview of operation
// - opcode EB takes three address bytes, or four when extended-address flag set
// - opcode EC always takes a four-byte address
// - address arrives four bits per serial clock on all data lines
// - opcode frames run only when configuration bit 1, four-line enable, is one
// - dummy cycles from latency code follow mode bits; data lines ignored then
// - dummy count identical in both latency tables, so no table select
// - data driven one nibble per clock, changing on falling clock edge
// - address increments per byte and wraps from top to zero
// - mode byte follows address and takes exactly two clocks
// - mode upper nibble A keeps continuous mode; next frame starts with address
// - mode lower nibble is ignored for the continuation decision
// - any other mode value leaves continuous mode at chip select rise
// - frame of eight clocks or fewer without valid opcode forces exit
`timescale 1ns/10ps
`default_nettype none
module qire_engine #(
	parameter int ADDR_W = 24,
	parameter int DATA_W = 8
) (
	input  wire logic              CORE_CLK_I,
	input  wire logic              RST_I,
	input  wire logic              SCK_I,
	input  wire logic              CS_N_I,
	input  wire logic [3:0]        IO_I,
	output logic [3:0]             IO_O,
	output logic [3:0]             IO_OE_O,
	input  wire logic              EXTENDED_ADDRESS_FLAG_I,
	input  wire logic [7:0]        CONFIGURATION_REGISTER_ONE_I,
	input  wire logic [3:0]        DUMMY_CYCLES_I,
	output logic                   EXECUTE_IN_PLACE_O,
	output logic                   BUSY_O,
	output logic                   RD_REQ_VALID_O,
	output logic [ADDR_W-1:0]      RD_REQ_ADDR_O,
	input  wire logic              RD_REQ_READY_I,
	input  wire logic              RD_DATA_VALID_I,
	input  wire logic [DATA_W-1:0] RD_DATA_I,
	output logic                   RD_DATA_READY_O
);
	// two-flop synchronisers for the link pins; stage one feeds only stage two
	logic [5:0] sync1;
	logic [5:0] sync2;
	logic       sck_d;
	logic       cs_d;
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			sync1 <= 6'h3F;
			sync2 <= 6'h3F;
			sck_d <= 1'b1;
			cs_d  <= 1'b1;
		end
		else
		begin
			sync1 <= {SCK_I, CS_N_I, IO_I};
			sync2 <= sync1;
			sck_d <= sync2[5];
			cs_d  <= sync2[4];
		end
	end
	logic       sck_s;
	logic       cs_n_s;
	logic [3:0] io_s;
	logic       sck_rise;
	logic       sck_fall;
	assign sck_s    = sync2[5];
	assign cs_n_s   = sync2[4];
	assign io_s     = sync2[3:0];
	assign sck_rise = sck_s & ~sck_d & ~cs_n_s;
	assign sck_fall = ~sck_s & sck_d & ~cs_n_s;
	// chip select edges found from the synchronised level and its one-cycle history
	logic cs_fall;
	logic cs_rise;
	assign cs_fall = cs_d & ~cs_n_s;
	assign cs_rise = ~cs_d & cs_n_s;
	qire_pkg::qire_state_e state;
	logic [7:0]            cnt;        // cycles in current phase
	logic [7:0]            clk_cnt;    // rising clocks in current frame
	logic [7:0]            opcode;
	logic [31:0]           addr;
	logic [7:0]            mode;
	logic                  execute_in_place;        // continuous mode active
	logic                  mode_keep;  // continuation seen in this frame
	logic [7:0]            addr_nibbles;
	logic                  quad_en;
	// quad enable gates the opcode decode; continuous frames bypass it
	assign quad_en = CONFIGURATION_REGISTER_ONE_I[qire_pkg::CFG_QUAD_BIT];
	// nibble count of the address phase for the decoded opcode
	function automatic logic [7:0] addr_len(input logic [7:0] op, input logic ext);
		if (op == qire_pkg::OPC_READ_WIDE)
			addr_len = 8'h08;
		else if (ext)
			addr_len = 8'h08;
		else
			addr_len = 8'h06;
	endfunction : addr_len
	// two-entry buffer between the array fetch and the nibble shifter
	logic [DATA_W-1:0] buf_mem [qire_pkg::BUF_DEPTH];
	logic              buf_wp;
	logic              buf_rp;
	logic [1:0]        buf_cnt;
	logic              buf_push;
	logic              buf_pop;
	logic [DATA_W-1:0] shift_byte;
	logic              nib_hi;     // high nibble goes out first
	logic              byte_loaded;
	assign RD_DATA_READY_O = (buf_cnt != 2'h2) & (state == qire_pkg::QIRE_DATA);
	assign buf_push        = RD_DATA_VALID_I & RD_DATA_READY_O;
	// pop when the shifter needs a fresh byte at a falling edge
	assign buf_pop = (buf_cnt != 2'h0) & (state == qire_pkg::QIRE_DATA)
		& sck_fall & (nib_hi | ~byte_loaded);
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			buf_wp  <= 1'b0;
			buf_rp  <= 1'b0;
			buf_cnt <= 2'h0;
		end
		else if (cs_rise)
		begin
			buf_wp  <= 1'b0;
			buf_rp  <= 1'b0;
			buf_cnt <= 2'h0;
		end
		else
		begin
			if (buf_push)
			begin
				buf_mem[buf_wp] <= RD_DATA_I;
				buf_wp          <= ~buf_wp;
			end
			if (buf_pop)
				buf_rp <= ~buf_rp;
			buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
		end
	end
	// array fetch requests: one per byte, address stepping with wrap
	logic fetch_pend;
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			RD_REQ_VALID_O <= 1'b0;
			RD_REQ_ADDR_O  <= '0;
			fetch_pend     <= 1'b0;
		end
		else if (cs_rise)
		begin
			RD_REQ_VALID_O <= 1'b0;
			fetch_pend     <= 1'b0;
		end
		else if (state == qire_pkg::QIRE_MODE && sck_rise && cnt == 8'h01)
		begin
			RD_REQ_VALID_O <= 1'b1;
			RD_REQ_ADDR_O  <= addr[ADDR_W-1:0];
		end
		else if (RD_REQ_VALID_O && RD_REQ_READY_I)
		begin
			RD_REQ_VALID_O <= 1'b0;
			fetch_pend     <= 1'b1;
			RD_REQ_ADDR_O  <= RD_REQ_ADDR_O + 1'b1; // wraps naturally at top
		end
		else if (fetch_pend && buf_push && buf_cnt == 2'h0)
		begin
			RD_REQ_VALID_O <= 1'b1; // keep one byte in flight ahead of the shifter
			fetch_pend     <= 1'b0;
		end
		else if (fetch_pend && buf_pop)
		begin
			RD_REQ_VALID_O <= 1'b1;
			fetch_pend     <= 1'b0;
		end
	end
	// command sequencer, stepped on synchronised rising serial clock edges
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			state        <= qire_pkg::QIRE_IDLE;
			cnt          <= 8'h00;
			opcode       <= 8'h00;
			addr         <= 32'h0000_0000;
			mode         <= 8'h00;
			addr_nibbles <= 8'h06;
		end
		else if (cs_rise)
			state <= qire_pkg::QIRE_IDLE;
		else if (cs_fall)
		begin
			cnt  <= 8'h00;
			addr <= 32'h0000_0000;
			if (execute_in_place)
			begin
				state        <= qire_pkg::QIRE_ADDR; // no opcode in continuous mode
				addr_nibbles <= addr_len(opcode, EXTENDED_ADDRESS_FLAG_I);
			end
			else
				state <= qire_pkg::QIRE_OPCODE;
		end
		else if (sck_rise)
		begin
			cnt <= cnt + 8'h01;
			case (state)
				qire_pkg::QIRE_OPCODE:
				begin
					opcode <= {opcode[6:0], io_s[0]};
					if (cnt == 8'(qire_pkg::OPC_BITS - 1))
					begin
						cnt <= 8'h00;
						if (quad_en && ({opcode[6:0], io_s[0]} == qire_pkg::OPC_READ
							|| {opcode[6:0], io_s[0]} == qire_pkg::OPC_READ_WIDE))
						begin
							state        <= qire_pkg::QIRE_ADDR;
							addr_nibbles <= addr_len({opcode[6:0], io_s[0]},
								EXTENDED_ADDRESS_FLAG_I);
						end
						else
							state <= qire_pkg::QIRE_IGNORE;
					end
				end
				qire_pkg::QIRE_ADDR:
				begin
					addr <= {addr[27:0], io_s};
					if (cnt == addr_nibbles - 8'h01)
					begin
						cnt   <= 8'h00;
						state <= qire_pkg::QIRE_MODE;
					end
				end
				qire_pkg::QIRE_MODE:
				begin
					mode <= {mode[3:0], io_s};
					if (cnt == 8'(qire_pkg::MODE_CYCLES - 1))
					begin
						cnt   <= 8'h00;
						state <= (DUMMY_CYCLES_I == 4'h0) ? qire_pkg::QIRE_DATA
							: qire_pkg::QIRE_DUMMY;
					end
				end
				qire_pkg::QIRE_DUMMY:
				begin
					// data lines not looked at here; one count serves both tables
					if (cnt == {4'h0, DUMMY_CYCLES_I} - 8'h01)
					begin
						cnt   <= 8'h00;
						state <= qire_pkg::QIRE_DATA;
					end
				end
				qire_pkg::QIRE_DATA,
				qire_pkg::QIRE_IDLE,
				qire_pkg::QIRE_IGNORE:
					cnt <= 8'h00;
				default:
					state <= qire_pkg::QIRE_IDLE;
			endcase
		end
	end
	// rising clocks counted per frame for the short-frame exit
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
			clk_cnt <= 8'h00;
		else if (cs_fall)
			clk_cnt <= 8'h00;
		else if (sck_rise && clk_cnt != 8'hFF)
			clk_cnt <= clk_cnt + 8'h01;
	end
	// continuation flag caught after both mode nibbles, lower nibble unused
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
			mode_keep <= 1'b0;
		else if (cs_fall)
			mode_keep <= 1'b0;
		else if (state == qire_pkg::QIRE_MODE && sck_rise
			&& cnt == 8'(qire_pkg::MODE_CYCLES - 1))
			mode_keep <= (mode[3:0] == qire_pkg::MODE_CONTINUE);
	end
	// continuous mode updated only at chip select rise; opcode frames never run with it set
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
			execute_in_place <= 1'b0;
		else if (cs_rise)
		begin
			if (state == qire_pkg::QIRE_DUMMY || state == qire_pkg::QIRE_DATA)
				execute_in_place <= mode_keep;
			else if (clk_cnt <= 8'(qire_pkg::EXIT_MAX_CLKS))
				execute_in_place <= 1'b0;
		end
	end
	assign EXECUTE_IN_PLACE_O = execute_in_place;
	// nibble shifter: output changes on falling serial clock, high nibble first
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			IO_O        <= 4'h0;
			IO_OE_O     <= 4'h0;
			shift_byte  <= '0;
			nib_hi      <= 1'b1;
			byte_loaded <= 1'b0;
		end
		else if (state != qire_pkg::QIRE_DATA || cs_n_s)
		begin
			IO_OE_O     <= 4'h0; // released until the host has let go of the lines
			nib_hi      <= 1'b1;
			byte_loaded <= 1'b0;
		end
		else if (sck_fall)
		begin
			IO_OE_O <= 4'hF;
			if (nib_hi || !byte_loaded)
			begin
				// an empty buffer stalls on the last byte rather than glitching
				if (buf_pop)
					shift_byte <= buf_mem[buf_rp];
				IO_O        <= buf_pop ? buf_mem[buf_rp][DATA_W-1:DATA_W-4]
					: shift_byte[DATA_W-1:DATA_W-4];
				nib_hi      <= 1'b0;
				byte_loaded <= 1'b1;
			end
			else
			begin
				IO_O   <= shift_byte[3:0];
				nib_hi <= 1'b1;
			end
		end
	end
	assign BUSY_O = (state != qire_pkg::QIRE_IDLE);
endmodule : qire_engine
`default_nettype wire

// ### bench/qire_chk.sv
// port checker for the four-line io read engine
`timescale 1ns/10ps
`default_nettype none
module qire_chk #(
	parameter int ADDR_W = 24
) (
	input wire logic              CORE_CLK_I,
	input wire logic              RST_I,
	input wire logic              SCK_I,
	input wire logic              CS_N_I,
	input wire logic [3:0]        IO_O,
	input wire logic [3:0]        IO_OE_O,
	input wire logic [7:0]        CONFIGURATION_REGISTER_ONE_I,
	input wire logic              EXECUTE_IN_PLACE_O,
	input wire logic              BUSY_O,
	input wire logic              RD_REQ_VALID_O,
	input wire logic [ADDR_W-1:0] RD_REQ_ADDR_O,
	input wire logic              RD_REQ_READY_I
);
	logic              have_last;
	logic [ADDR_W-1:0] last_addr;
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	// last fetch address of this frame; idle wins so a late fetch never links two frames
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
			have_last <= 1'b0;
		else if (!BUSY_O)
			have_last <= 1'b0;
		else if (RD_REQ_VALID_O && RD_REQ_READY_I)
			have_last <= 1'b1;
	end
	// address of each accepted fetch
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RD_REQ_VALID_O && RD_REQ_READY_I)
			last_addr <= RD_REQ_ADDR_O;
	end
	AST_OE_ALL: assert property (IO_OE_O == 4'h0 || IO_OE_O == 4'hF)
		else $error("data lines not driven as one nibble");
	AST_OE_OFF: assert property (CS_N_I [*6] |-> IO_OE_O == 4'h0)
		else $error("data lines driven while deselected");
	AST_NO_QUAD: assert property (!CONFIGURATION_REGISTER_ONE_I[1] && !EXECUTE_IN_PLACE_O
		|-> IO_OE_O == 4'h0)
		else $error("data driven with four-line enable clear");
	AST_IO_EDGE: assert property ($changed(IO_O) && IO_OE_O == 4'hF
		|-> !$past(SCK_I) && !$past(SCK_I, 2))
		else $error("data nibble changed away from a falling clock");
	AST_REQ_HOLD: assert property (RD_REQ_VALID_O && !RD_REQ_READY_I && BUSY_O && !CS_N_I
		|=> RD_REQ_VALID_O && $stable(RD_REQ_ADDR_O))
		else $error("fetch request dropped before acceptance");
	AST_ADDR_INC: assert property (RD_REQ_VALID_O && have_last
		|-> RD_REQ_ADDR_O == last_addr + 1'b1)
		else $error("fetch address not incremented");
	AST_XIP_SET: assert property ($rose(EXECUTE_IN_PLACE_O) |-> CS_N_I && $past(CS_N_I, 2))
		else $error("continuous mode entered inside a frame");
	AST_XIP_CLR: assert property ($fell(EXECUTE_IN_PLACE_O) |-> CS_N_I && $past(CS_N_I, 2))
		else $error("continuous mode left inside a frame");
endmodule : qire_chk
`default_nettype wire

// ### bench/qire_host.sv
// behavioural mode-0 spi host on four data lines
`timescale 1ns/10ps
`default_nettype none
module qire_host (
	output logic       sck_o,
	output logic       cs_n_o,
	output logic [3:0] io_o,
	output logic       oe_o,
	input  wire logic [3:0] io_i
);
	logic [7:0] rd [0:7];
	logic [3:0] r;
	logic [3:0] h;
	// idle bus: clock low, deselected, lines released
	initial
	begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		io_o = 4'h0;
		oe_o = 1'b0;
	end
	// one clock: lines set while low, device answer taken at the rise
	task automatic cyc(input logic [3:0] n);
		io_o = n;
		#80 sck_o = 1'b1;
		h = r;
		r = io_i;
		#80 sck_o = 1'b0;
	endtask : cyc
	task automatic frame(input logic on, input logic [7:0] op, input logic [31:0] ad,
		input int an, input logic [7:0] md, input int dm, input int nb);
		cs_n_o = 1'b0;
		oe_o = 1'b1;
		#80;
		for (int i = 7; i >= 0; i--)
			if (on) cyc({3'h5, op[i]});
		for (int i = an - 1; i >= 0; i--)
			cyc(ad[4*i +: 4]);
		cyc(md[7:4]);
		oe_o = 1'b0;
		cyc(md[3:0]);
		repeat (dm) cyc(4'h0);
		for (int b = 0; b < 2 * nb; b++)
		begin
			cyc(4'h0);
			if (b[0]) rd[b/2] = {h, r};
		end
		cs_n_o = 1'b1;
		#160;
	endtask : frame
	// short frame of n clocks with no valid opcode on the lines
	task automatic stub(input int n);
		cs_n_o = 1'b0;
		oe_o = 1'b1;
		repeat (n) cyc(4'hF);
		cs_n_o = 1'b1;
		oe_o = 1'b0;
		#160;
	endtask : stub
endmodule : qire_host
`default_nettype wire

// ### bench/qire_engine_tb_top.sv
// testbench for the four-line io read engine
`timescale 1ns/10ps
`default_nettype none
module qire_engine_tb_top;
	localparam int ADDR_W = 24;
	logic              CORE_CLK_I, RST_I, ext, slow, dv, rdy, pend, hs, ds, h_oe, sck, cs_n;
	logic              execute_in_place, busy, rq_v, dr;
	logic [7:0]        cfg, dat;
	logic [3:0]        dum, h_io, io_q, io_o, io_oe;
	logic [ADDR_W-1:0] rq_a, p_a, ha;
	wire logic [3:0]   io_w;
	int                err_count, samples_checked, cnt;
	qire_engine #(.ADDR_W(ADDR_W), .DATA_W(8)) i_dut (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I),
		.SCK_I(sck), .CS_N_I(cs_n), .IO_I(io_w), .IO_O(io_o), .IO_OE_O(io_oe),
		.EXTENDED_ADDRESS_FLAG_I(ext), .CONFIGURATION_REGISTER_ONE_I(cfg),
		.DUMMY_CYCLES_I(dum), .EXECUTE_IN_PLACE_O(execute_in_place), .BUSY_O(busy), .RD_REQ_VALID_O(rq_v),
		.RD_REQ_ADDR_O(rq_a), .RD_REQ_READY_I(rdy), .RD_DATA_VALID_I(dv), .RD_DATA_I(dat),
		.RD_DATA_READY_O(dr));
	qire_host i_host (.sck_o(sck), .cs_n_o(cs_n), .io_o(h_io), .oe_o(h_oe), .io_i(io_w));
	// a line nobody drives shows the inverse of its last level, so stale data cannot pass
	assign io_w = (io_oe & io_o) | (~io_oe & {4{h_oe}} & h_io) | (~io_oe & ~{4{h_oe}} & ~io_q);
	always @(posedge CORE_CLK_I)
		if (io_oe != 4'h0 || h_oe) io_q <= io_w;
	initial
	begin
		CORE_CLK_I = 1'b0;
		forever #5 CORE_CLK_I = ~CORE_CLK_I;
	end
	function automatic logic [7:0] pat(input logic [ADDR_W-1:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3C;
	endfunction : pat
	// byte store behind the fetch port; slow mode stalls ready three cycles of four
	always @(posedge CORE_CLK_I)
	begin
		hs = rq_v && rdy;
		ds = dv && dr;
		ha = rq_a;
		#1;
		cnt++;
		rdy = !slow || cnt[1:0] == 2'h0;
		if (ds) dv = 1'b0;
		if (pend && !dv)
		begin
			dv = 1'b1;
			dat = pat(p_a);
			pend = 1'b0;
		end
		if (hs)
		begin
			pend = 1'b1;
			p_a = ha;
		end
	end
	task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] sn);
		samples_checked++;
		if (sn !== ex)
		begin
			err_count++;
			$display("FAIL %s expected %h seen %h", nm, ex, sn);
		end
	endtask : chk
	task automatic rd(input logic on, input logic [7:0] op, input logic [31:0] ad, input int an,
		input logic [7:0] md, input int nb, input logic xe);
		i_host.frame(on, op, ad, an, md, dum, nb);
		for (int b = 0; b < nb; b++)
			chk("byte", pat(ad[ADDR_W-1:0] + b[ADDR_W-1:0]), i_host.rd[b]);
		chk("xip", {7'h0, xe}, {7'h0, execute_in_place});
	endtask : rd
	task automatic test_done;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	// cut a hang short after nearly twenty times the expected run
	initial
	begin
		#500000;
		err_count++;
		test_done;
	end
	initial
	begin
		RST_I = 1'b1;
		{ext, slow, dv, pend, rdy, cnt} = '0;
		{cfg, dum, dat, io_q} = {8'h02, 4'h2, 8'h00, 4'h0};
		err_count = 0;
		samples_checked = 0;
		repeat (5) @(posedge CORE_CLK_I);
		#1 RST_I = 1'b0;
		repeat (4) @(posedge CORE_CLK_I);
		#1;
		rd(1, qire_pkg::OPC_READ, 32'h00FFFFFE, 6, 8'h00, 4, 0);
		slow = 1'b1;
		dum = 4'h5;
		rd(1, qire_pkg::OPC_READ_WIDE, 32'h12345678, 8, 8'hA5, 3, 1);
		// continuous frames keep the wide address of the frame that opened the mode
		rd(0, 8'h00, 32'h00ABCDEF, 8, 8'hA0, 2, 1);
		rd(0, 8'h00, 32'h00000010, 8, 8'h50, 2, 0);
		{ext, slow, dum} = {1'b1, 1'b0, 4'h0};
		rd(1, qire_pkg::OPC_READ, 32'h89ABCDEF, 8, 8'hA0, 2, 1);
		i_host.stub(4);
		chk("xip", 8'h00, {7'h0, execute_in_place});
		ext = 1'b0;
		rd(1, 8'h03, 32'h0, 6, 8'hA0, 0, 0);
		cfg = 8'hFD;
		rd(1, qire_pkg::OPC_READ, 32'h0, 6, 8'hA0, 0, 0);
		test_done;
	end
endmodule : qire_engine_tb_top
bind qire_engine qire_chk #(.ADDR_W(ADDR_W)) i_chk (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I),
	.SCK_I(SCK_I), .CS_N_I(CS_N_I), .IO_O(IO_O), .IO_OE_O(IO_OE_O), .BUSY_O(BUSY_O),
	.CONFIGURATION_REGISTER_ONE_I(CONFIGURATION_REGISTER_ONE_I), .RD_REQ_ADDR_O(RD_REQ_ADDR_O),
	.EXECUTE_IN_PLACE_O(EXECUTE_IN_PLACE_O), .RD_REQ_VALID_O(RD_REQ_VALID_O),
	.RD_REQ_READY_I(RD_REQ_READY_I));
`default_nettype wire
